/* hw/nvsc_pkg.sv */
package nvsc_pkg;
   // Memory geometry.
   localparam int NVSC_ADDR_W = 9;
   localparam int NVSC_DATA_W = 8;
   localparam int NVSC_DEPTH = 512;
   // Clock rate in MHz (100 MHz, 10 ns period).
   localparam int NVSC_CLK_MHZ = 100;
   // Timing figures in their own units.
   localparam int NVSC_INIT_NS = 20;
   localparam int NVSC_ACCESS_NS = 45;
   localparam int NVSC_SAVE_MS = 10;
   localparam int NVSC_RESTORE_US = 20;
   localparam int NVSC_POWERUP_US = 550;
   // Derived cycle counts (minimum times rounded up).
   localparam int NVSC_INIT_CYC = (NVSC_INIT_NS * NVSC_CLK_MHZ + 999) / 1000;
   localparam int NVSC_ACCESS_CYC = (NVSC_ACCESS_NS * NVSC_CLK_MHZ + 999) / 1000;
   localparam int NVSC_SAVE_CYC = NVSC_SAVE_MS * 1000 * NVSC_CLK_MHZ;
   localparam int NVSC_RESTORE_CYC = NVSC_RESTORE_US * NVSC_CLK_MHZ;
   localparam int NVSC_POWERUP_CYC = NVSC_POWERUP_US * NVSC_CLK_MHZ;
   localparam int NVSC_CNT_W = 24;

   // Host request codes.
   typedef enum logic [1:0] {
      NVSC_OP_READ,
      NVSC_OP_WRITE,
      NVSC_OP_SAVE,
      NVSC_OP_RESTORE
   } nvsc_op_t;

   // Control pins toward the memory, all active low.
   typedef struct packed {
      logic chip_enable_n;
      logic output_enable_n;
      logic write_enable_n;
      logic nonvolatile_enable_n;
   } nvsc_ctl_t;

   localparam nvsc_ctl_t NVSC_CTL_IDLE = 4'hf;
endpackage : nvsc_pkg

/* hw/nvsc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Host keeps address stable across the whole write.
// - Host keeps output enable high during writes to avoid contention.
// - Host enters save state with write enable as the last falling signal.
// - Host holds save state at least 20 ns, then may release.
// - Host holds restore state at least 20 ns, then releases.
// - Host makes no access until the power-up restore time has passed.
// - Host presents no write state when power-up restore ends.
module nvsc_host
   import nvsc_pkg::*;
#(
   parameter int POWERUP_CYC = NVSC_POWERUP_CYC,
   parameter int SAVE_CYC = NVSC_SAVE_CYC,
   parameter int RESTORE_CYC = NVSC_RESTORE_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire nvsc_op_t req_op,
   input wire logic [NVSC_ADDR_W-1:0] req_addr,
   input wire logic [NVSC_DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [NVSC_DATA_W-1:0] rsp_rdata,
   output nvsc_ctl_t mem_ctl,
   output logic [NVSC_ADDR_W-1:0] address_bus,
   output logic [NVSC_DATA_W-1:0] data_bus_o,
   output logic data_bus_oe,
   input wire logic [NVSC_DATA_W-1:0] data_bus_i
);
   typedef enum logic [2:0] {
      NVSC_S_POWERUP, NVSC_S_IDLE, NVSC_S_SETUP, NVSC_S_PULSE, NVSC_S_RELEASE, NVSC_S_WAIT
   } nvsc_state_t;

   // All counts share one counter width; the save figure is the largest and still fits.
   localparam logic [NVSC_CNT_W-1:0] INIT_C = NVSC_CNT_W'(NVSC_INIT_CYC);
   localparam logic [NVSC_CNT_W-1:0] ACC_C = NVSC_CNT_W'(NVSC_ACCESS_CYC);
   localparam logic [NVSC_CNT_W-1:0] PWR_C = NVSC_CNT_W'(POWERUP_CYC);
   localparam logic [NVSC_CNT_W-1:0] SAVE_C = NVSC_CNT_W'(SAVE_CYC);
   localparam logic [NVSC_CNT_W-1:0] REST_C = NVSC_CNT_W'(RESTORE_CYC);
   localparam logic [NVSC_CNT_W-1:0] ONE_C = NVSC_CNT_W'(1);

   nvsc_state_t state;
   nvsc_op_t op;
   logic [NVSC_CNT_W-1:0] cnt;
   logic [NVSC_DATA_W-1:0] rd_s1, rd_s2, rd_s3, rd_q;

   // Three-stage sampler on the returning data bus, which settles outside this clock's control.
   always_ff @(posedge clk) begin
      rd_s1 <= data_bus_i;
      rd_s2 <= rd_s1;
      rd_s3 <= rd_s2;
   end

   // A new byte is accepted only once stages two and three agree.
   // This keeps a bus caught in mid-change out of the read result.
   always_ff @(posedge clk) begin
      if (rd_s2 == rd_s3) begin
         rd_q <= rd_s3;
      end
   end

   // Sequencer: each access goes through setup, strobe, release; nonvolatile ops then wait blind.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= NVSC_S_POWERUP;
         op <= NVSC_OP_READ;
         cnt <= PWR_C;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
         mem_ctl <= NVSC_CTL_IDLE;
         address_bus <= '0;
         data_bus_o <= '0;
         data_bus_oe <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         case (state)
            NVSC_S_POWERUP: begin
               // Controls stay idle, so no write state exists when the power-up restore ends.
               mem_ctl <= NVSC_CTL_IDLE;
               if (cnt == ONE_C) begin
                  state <= NVSC_S_IDLE;
                  req_ready <= 1'b1;
               end
               cnt <= cnt - ONE_C;
            end
            NVSC_S_IDLE: begin
               if (req_valid) begin
                  req_ready <= 1'b0;
                  op <= req_op;
                  address_bus <= req_addr;
                  data_bus_o <= req_wdata;
                  state <= NVSC_S_SETUP;
                  // Output enable is raised first for writes and saves to keep the bus free.
                  mem_ctl.output_enable_n <= (req_op != NVSC_OP_READ && req_op != NVSC_OP_RESTORE);
                  mem_ctl.nonvolatile_enable_n <= !(req_op == NVSC_OP_SAVE || req_op == NVSC_OP_RESTORE);
                  mem_ctl.write_enable_n <= 1'b1;
                  mem_ctl.chip_enable_n <= 1'b1;
               end
            end
            NVSC_S_SETUP: begin
               // Chip enable falls after the others; for writes and saves write enable falls last.
               mem_ctl.chip_enable_n <= 1'b0;
               data_bus_oe <= (op == NVSC_OP_WRITE);
               cnt <= (op == NVSC_OP_READ) ? ACC_C : INIT_C;
               state <= NVSC_S_PULSE;
            end
            NVSC_S_PULSE: begin
               // The strobe is held for the initiation time, or for the access time on reads.
               if (op == NVSC_OP_WRITE || op == NVSC_OP_SAVE) begin
                  mem_ctl.write_enable_n <= 1'b0;
               end
               if (cnt == ONE_C) begin
                  state <= NVSC_S_RELEASE;
               end
               cnt <= cnt - ONE_C;
            end
            NVSC_S_RELEASE: begin
               // Write enable rises first and ends the write with data still driven.
               mem_ctl.write_enable_n <= 1'b1;
               mem_ctl.chip_enable_n <= (op == NVSC_OP_WRITE) ? 1'b0 : 1'b1;
               if (op == NVSC_OP_READ) begin
                  rsp_rdata <= rd_q;
                  rsp_valid <= 1'b1;
               end
               case (op)
                  NVSC_OP_SAVE: cnt <= SAVE_C;
                  NVSC_OP_RESTORE: cnt <= REST_C;
                  default: cnt <= ONE_C;
               endcase
               state <= NVSC_S_WAIT;
            end
            NVSC_S_WAIT: begin
               // The memory has no ready pin, so this wait is blind and sized for the slowest case.
               mem_ctl <= NVSC_CTL_IDLE;
               data_bus_oe <= 1'b0;
               if (cnt == ONE_C) begin
                  state <= NVSC_S_IDLE;
                  req_ready <= 1'b1;
               end
               cnt <= cnt - ONE_C;
            end
            default: state <= NVSC_S_IDLE;
         endcase
      end
   end

   // Counts the cycles spent in the power-up hold, so its length can be checked from outside the sequencer.
   logic [NVSC_CNT_W-1:0] up_cnt;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         up_cnt <= '0;
      end else if (state == NVSC_S_POWERUP) begin
         up_cnt <= up_cnt + ONE_C;
      end
   end

   // Pin order and hold checks on what this controller drives toward the memory, plus checks on req_ready and the power-up hold length.
   a_no_drive_on_read: assert property (@(posedge clk) disable iff (!rst_n)
      (!mem_ctl.output_enable_n && !mem_ctl.chip_enable_n) |-> !data_bus_oe)
      else $error("Bus driven while memory outputs enabled.");
   a_write_last_fall: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(mem_ctl.write_enable_n) |-> !mem_ctl.chip_enable_n)
      else $error("Write enable was not the last to fall.");
   a_save_no_oe: assert property (@(posedge clk) disable iff (!rst_n)
      (!mem_ctl.write_enable_n && !mem_ctl.nonvolatile_enable_n) |-> mem_ctl.output_enable_n)
      else $error("Save state with output enable low.");
   a_addr_stable: assert property (@(posedge clk) disable iff (!rst_n)
      !mem_ctl.write_enable_n |-> $stable(address_bus))
      else $error("Address moved during a write.");
   a_powerup_idle: assert property (@(posedge clk) disable iff (!rst_n)
      state == NVSC_S_POWERUP |-> (mem_ctl == NVSC_CTL_IDLE && !req_ready))
      else $error("Activity during power-up restore.");
   a_hold_min: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(mem_ctl.chip_enable_n) && !mem_ctl.nonvolatile_enable_n |-> !mem_ctl.chip_enable_n [*2])
      else $error("Nonvolatile initiation held too briefly.");
   a_busy_wait: assert property (@(posedge clk) disable iff (!rst_n)
      (state == NVSC_S_WAIT && op == NVSC_OP_RESTORE) |-> !req_ready)
      else $error("Ready during restore wait.");
   a_ready_idle: assert property (@(posedge clk) disable iff (!rst_n)
      req_ready |-> mem_ctl == NVSC_CTL_IDLE)
      else $error("Ready while pins not idle.");
   a_save_hold: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(mem_ctl.write_enable_n) && !mem_ctl.nonvolatile_enable_n |-> !mem_ctl.write_enable_n [*2])
      else $error("Save initiation held too briefly.");
   a_save_wait: assert property (@(posedge clk) disable iff (!rst_n)
      (state == NVSC_S_WAIT && op == NVSC_OP_SAVE) |-> !req_ready)
      else $error("Ready during save wait.");
   a_restore_write_high: assert property (@(posedge clk) disable iff (!rst_n)
      (!mem_ctl.nonvolatile_enable_n && !mem_ctl.output_enable_n) |-> mem_ctl.write_enable_n)
      else $error("Write enable low during a restore.");
   a_write_data_held: assert property (@(posedge clk) disable iff (!rst_n)
      (!mem_ctl.write_enable_n && mem_ctl.nonvolatile_enable_n) |-> data_bus_oe)
      else $error("Write data released before the write ended.");
   a_powerup_length: assert property (@(posedge clk) disable iff (!rst_n)
      ($rose(req_ready) && $past(state) == NVSC_S_POWERUP) |-> up_cnt == PWR_C)
      else $error("Power-up hold of the wrong length.");

   // Main scenarios that the bench is expected to reach.
   c_read: cover property (@(posedge clk) rsp_valid);
   c_write: cover property (@(posedge clk) $rose(mem_ctl.write_enable_n) && mem_ctl.nonvolatile_enable_n);
   c_save: cover property (@(posedge clk) state == NVSC_S_WAIT && op == NVSC_OP_SAVE);
   c_restore: cover property (@(posedge clk) state == NVSC_S_WAIT && op == NVSC_OP_RESTORE);
endmodule // nvsc_host
`default_nettype wire

/* verification/nvsc_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nvsc_mem_model
   import nvsc_pkg::*;
#(
   parameter int SAVE_T = 16,
   parameter int RESTORE_T = 16
) (
   input wire logic clk,
   input wire nvsc_ctl_t ctl,
   input wire logic [NVSC_ADDR_W-1:0] addr,
   input wire logic [NVSC_DATA_W-1:0] din,
   input wire logic supply_low,
   output logic [NVSC_DATA_W-1:0] dout,
   output logic dout_en
);
   logic [NVSC_DATA_W-1:0] sram [NVSC_DEPTH];
   logic [NVSC_DATA_W-1:0] nv [NVSC_DEPTH];
   nvsc_ctl_t prev = NVSC_CTL_IDLE;
   int busy = RESTORE_T;
   logic saving = 1'b0;
   // Pin states decoded from the four active-low controls, in struct order.
   wire logic st = (ctl == 4'h4);
   wire logic rc = (ctl == 4'h2);
   wire logic rd = (ctl == 4'h3);
   wire logic pw = !prev.chip_enable_n && !prev.write_enable_n && prev.nonvolatile_enable_n;
   // A known pattern sits in the shadow; power-up starts a restore from it.
   initial begin
      for (int i = 0; i < NVSC_DEPTH; i++) begin
         nv[i] = 8'(i) ^ 8'h5a;
         sram[i] = 8'h00;
      end
   end
   // Pins are ignored while busy; only a transition starts a save or restore, never a held level.
   always @(posedge clk) begin
      if (busy > 0) begin
         busy--;
         if (busy == 0) begin
            for (int i = 0; i < NVSC_DEPTH; i++) begin
               if (saving) nv[i] = sram[i];
               else sram[i] = nv[i];
            end
         end
      end else if (st && prev != 4'h4 && !supply_low) begin
         saving = 1'b1;
         busy = SAVE_T;
      end else if (rc && prev != 4'h2) begin
         saving = 1'b0;
         busy = RESTORE_T;
         for (int i = 0; i < NVSC_DEPTH; i++) sram[i] = 8'h00;
      end else if (pw && !(!ctl.chip_enable_n && !ctl.write_enable_n)) begin
         sram[addr] = din;
      end
      prev = ctl;
   end
   // Drivers are on only when idle in the read state, so a write or busy time releases the bus.
   assign dout_en = (busy == 0) && rd;
   assign dout = sram[addr];
endmodule // nvsc_mem_model
`default_nettype wire

/* verification/nvsc_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module nvsc_host_tb;
   import nvsc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   nvsc_op_t req_op = NVSC_OP_READ;
   logic [NVSC_ADDR_W-1:0] req_addr = '0;
   logic [NVSC_DATA_W-1:0] req_wdata = '0;
   logic req_ready, rsp_valid, data_bus_oe, dev_en;
   logic [NVSC_DATA_W-1:0] rsp_rdata, data_bus_o, dev_out;
   logic [NVSC_DATA_W-1:0] last = '0;
   nvsc_ctl_t mem_ctl;
   logic [NVSC_ADDR_W-1:0] address_bus, a;
   logic [NVSC_DATA_W-1:0] exp_sram [NVSC_DEPTH];
   logic [NVSC_DATA_W-1:0] exp_nv [NVSC_DEPTH];
   int mismatches = 0;
   int tests_run = 0;
   logic supply_low = 1'b0;
   localparam int PWR_T = 20;
   // Contents the shadow holds from the start.
   function automatic logic [NVSC_DATA_W-1:0] shadow_byte(input int i);
      return 8'(i) ^ 8'h5a;
   endfunction
   // Shared wire: host first, then memory, else a released line that keeps flipping.
   wire logic [NVSC_DATA_W-1:0] data_bus_i = data_bus_oe ? data_bus_o : dev_en ? dev_out : ~last;
   always #5 clk = ~clk;
   always @(posedge clk) last <= data_bus_i;
   nvsc_host #(.POWERUP_CYC(PWR_T), .SAVE_CYC(20), .RESTORE_CYC(20)) dut_u (.clk(clk), .rst_n(rst_n),
      .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_ctl(mem_ctl),
      .address_bus(address_bus), .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe), .data_bus_i(data_bus_i));
   nvsc_mem_model mem_u (.clk(clk), .ctl(mem_ctl), .addr(address_bus), .din(data_bus_i),
      .supply_low(supply_low), .dout(dev_out), .dout_en(dev_en));
   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Waits for ready under a bound, issues one request, and checks read data against the expected SRAM copy.
   task automatic issue(input nvsc_op_t op, input logic [8:0] ad, input logic [7:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
      if (n == 100) begin mismatches++; give_verdict(); end
      req_valid = 1'b1;
      req_op = op;
      req_addr = ad;
      req_wdata = d;
      @(negedge clk);
      req_valid = 1'b0;
      n = 0;
      while (op == NVSC_OP_READ && rsp_valid !== 1'b1 && n < 20) begin @(negedge clk); n++; end
      if (n == 20) begin mismatches++; give_verdict(); end
      if (op == NVSC_OP_READ) chk8(rsp_rdata, exp_sram[ad]);
      if (op == NVSC_OP_WRITE) exp_sram[ad] = d;
      if (op == NVSC_OP_SAVE && !supply_low) exp_nv = exp_sram;
      if (op == NVSC_OP_RESTORE) exp_sram = exp_nv;
   endtask
   // Output enable must stay high whenever the host drives the data bus.
   always @(negedge clk) if (data_bus_oe === 1'b1) chk8({7'h0, mem_ctl.output_enable_n}, 8'h01);
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h874f_3cb7));
      for (int i = 0; i < NVSC_DEPTH; i++) exp_nv[i] = shadow_byte(i);
      exp_sram = exp_nv;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      chk8({4'h0, mem_ctl}, {4'h0, NVSC_CTL_IDLE});
      repeat (PWR_T - 1) @(negedge clk);
      chk8({7'h0, req_ready}, 8'h00);
      @(negedge clk);
      chk8({7'h0, req_ready}, 8'h01);
      issue(NVSC_OP_READ, 9'h000, 8'h00);
      issue(NVSC_OP_READ, 9'h1ff, 8'h00);
      for (int k = 0; k < 8; k++) begin
         a = 9'($urandom);
         issue(NVSC_OP_WRITE, a, 8'($urandom));
         issue(NVSC_OP_WRITE, 9'h1ff, 8'($urandom));
         issue(NVSC_OP_READ, a, 8'h00);
      end
      issue(NVSC_OP_SAVE, 9'h000, 8'h00);
      issue(NVSC_OP_WRITE, a, ~exp_sram[a]);
      issue(NVSC_OP_WRITE, 9'h1ff, ~exp_sram[9'h1ff]);
      issue(NVSC_OP_READ, a, 8'h00);
      issue(NVSC_OP_RESTORE, 9'h000, 8'h00);
      issue(NVSC_OP_READ, a, 8'h00);
      issue(NVSC_OP_WRITE, a, 8'h00);
      supply_low = 1'b1;
      issue(NVSC_OP_SAVE, 9'h000, 8'h00);
      issue(NVSC_OP_RESTORE, 9'h000, 8'h00);
      supply_low = 1'b0;
      issue(NVSC_OP_READ, a, 8'h00);
      issue(NVSC_OP_READ, 9'h1ff, 8'h00);
      give_verdict();
   end
endmodule // nvsc_host_tb
`default_nettype wire
